// File: design/wdu_pkg.sv
// Constants for the watchpoint debug unit: register map, field positions and widths.
// Assumes a single core clock and a scan controller that pulses capture, shift and update.
package wdu_pkg;

    // Scan chain layout: data field, address field, read/write bit.
    localparam int SCAN_LEN      = 38;
    localparam int SCAN_DATA_W   = 32;
    localparam int SCAN_ADDR_W   = 5;
    localparam int SCAN_ADDR_LSB = 32;
    localparam int SCAN_RW_BIT   = 37;

    // Register addresses inside the scan address field.
    localparam logic [4:0] ADDR_DEBUG_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_DEBUG_STATUS  = 5'h01;
    localparam logic [4:0] ADDR_WP0_BASE      = 5'h08;
    localparam logic [4:0] ADDR_WP1_BASE      = 5'h10;

    // Offsets of the six registers inside a watchpoint group.
    localparam logic [2:0] WP_ADDR_VALUE = 3'h0;
    localparam logic [2:0] WP_ADDR_MASK  = 3'h1;
    localparam logic [2:0] WP_DATA_VALUE = 3'h2;
    localparam logic [2:0] WP_DATA_MASK  = 3'h3;
    localparam logic [2:0] WP_CTRL_VALUE = 3'h4;
    localparam logic [2:0] WP_CTRL_MASK  = 3'h5;

    // Register widths.
    localparam int CONTROL_W   = 3;
    localparam int STATUS_W    = 5;
    localparam int CTRL_VAL_W  = 9;
    localparam int CTRL_MASK_W = 8;

    // Debug control bits.
    localparam int CTL_FORCE_ACK = 0;
    localparam int CTL_FORCE_REQ = 1;
    localparam int CTL_IRQ_INH   = 2;

    // Watchpoint control value bits.
    localparam int CV_ENABLE = 8;

    // Reset values.
    localparam logic [2:0]  CONTROL_RESET = 3'h0;
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
    localparam logic [8:0]  CTRL_RESET    = 9'h000;

    // Half-word lane masks used for 16-bit instruction fetches.
    localparam logic [31:0] LOW_HALF_IGNORE  = 32'h0000_ffff;
    localparam logic [31:0] HIGH_HALF_IGNORE = 32'hffff_0000;

endpackage : wdu_pkg

// File: design/watchpoint_debug_unit.sv
// Two-watchpoint debug comparator unit with debug control and status registers.
// Assumes all inputs are synchronous to mclk and the scan controller drives one-cycle strobes.
`timescale 1ns/1ps

module watchpoint_debug_unit
    import wdu_pkg::*;
#(
    parameter int NUM_WP = 2
)
(
    input  wire logic        mclk,
    input  wire logic        srst,
    // Scan chain strobes from the test controller.
    input  wire logic        scan_capture,
    input  wire logic        scan_shift,
    input  wire logic        scan_update,
    input  wire logic        scan_in,
    output logic             scan_out,
    // Core bus cycle being watched.
    input  wire logic        bus_cycle_valid,
    input  wire logic [31:0] core_addr,
    input  wire logic [31:0] core_data,
    input  wire logic        core_write,
    input  wire logic [1:0]  core_size,
    input  wire logic        access_kind_bit,
    input  wire logic        privilege_bit,
    input  wire logic        translate_flag,
    input  wire logic        instruction_state_flag,
    input  wire logic        interrupt_enable_status,
    input  wire logic        core_debug_ack,
    input  wire logic        ext_debug_request,
    input  wire logic [1:0]  external_condition,
    input  wire logic        debug_unit_enable,
    input  wire logic        irq_in,
    input  wire logic        fiq_in,
    // Results toward the core and the system.
    output logic             break_request,
    output logic             debug_request,
    output logic             debug_ack,
    output logic             irq_out,
    output logic             fiq_out,
    output logic             range_out,
    output logic             sequence_link_out
);

    if (NUM_WP != 2) begin : g_bad_wp
        $error("watchpoint_debug_unit serves exactly two watchpoints");
    end

    logic [SCAN_LEN-1:0]    shift_q;
    logic [31:0]            rd_hold_q;
    logic [CONTROL_W-1:0]   control_q;
    logic [31:0]            addr_val_q  [NUM_WP];
    logic [31:0]            addr_mask_q [NUM_WP];
    logic [31:0]            data_val_q  [NUM_WP];
    logic [31:0]            data_mask_q [NUM_WP];
    logic [CTRL_VAL_W-1:0]  ctrl_val_q  [NUM_WP];
    logic [CTRL_MASK_W-1:0] ctrl_mask_q [NUM_WP];
    logic [1:0]             ext_q;
    logic                   chain_q;
    logic                   req_s1_q;
    logic                   req_s2_q;
    logic                   st_req_s1_q;
    logic                   st_req_s2_q;
    logic                   st_ack_s1_q;
    logic                   st_ack_s2_q;
    logic                   break_q;
    logic                   dbg_req_q;
    logic                   dbg_ack_q;
    logic                   irq_q;
    logic                   fiq_q;
    logic                   range_q;
    logic                   tdo_q;

    logic [4:0]             upd_addr;
    logic                   upd_write;
    logic                   upd_read;
    logic                   wp_sel     [NUM_WP];
    logic [2:0]             wp_reg;
    logic [NUM_WP-1:0]      addr_ok;
    logic [NUM_WP-1:0]      data_ok;
    logic [NUM_WP-1:0]      ctrl_ok;
    logic [NUM_WP-1:0]      wp_match;
    logic [NUM_WP-1:0]      wp_fire;
    logic [NUM_WP-1:0]      ctrl_val_wr;
    logic [31:0]            half_ignore;
    logic                   eff_ack;
    logic [STATUS_W-1:0]    status_now;
    logic [31:0]            rd_mux;

    assign upd_addr  = shift_q[SCAN_ADDR_LSB +: SCAN_ADDR_W];
    assign upd_write = scan_update & shift_q[SCAN_RW_BIT];
    assign upd_read  = scan_update & ~shift_q[SCAN_RW_BIT];
    assign wp_reg    = upd_addr[2:0];
    assign wp_sel[0] = (upd_addr[4:3] == ADDR_WP0_BASE[4:3]);
    assign wp_sel[1] = (upd_addr[4:3] == ADDR_WP1_BASE[4:3]);

    // Scan chain: capture loads the held read word, shift moves toward scan_out.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            shift_q <= '0;
        end
        else if (scan_capture)
        begin
            shift_q[SCAN_DATA_W-1:0] <= rd_hold_q;
        end
        else if (scan_shift)
        begin
            shift_q <= {scan_in, shift_q[SCAN_LEN-1:1]};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tdo_q <= 1'b0;
        end
        else
        begin
            tdo_q <= shift_q[0];
        end
    end

    // Debug control register.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            control_q <= CONTROL_RESET;
        end
        else if (upd_write && upd_addr == ADDR_DEBUG_CONTROL)
        begin
            control_q <= shift_q[CONTROL_W-1:0];
        end
    end

    // Watchpoint register file.
    for (genvar i = 0; i < NUM_WP; i++)
    begin : g_wp_regs
        assign ctrl_val_wr[i] = upd_write & wp_sel[i] & (wp_reg == WP_CTRL_VALUE);

        always_ff @(posedge mclk)
        begin
            if (srst)
            begin
                addr_val_q[i]  <= WORD_RESET;
                addr_mask_q[i] <= WORD_RESET;
                data_val_q[i]  <= WORD_RESET;
                data_mask_q[i] <= WORD_RESET;
                ctrl_val_q[i]  <= CTRL_RESET;
                ctrl_mask_q[i] <= CTRL_RESET[CTRL_MASK_W-1:0];
            end
            else if (upd_write && wp_sel[i])
            begin
                case (wp_reg)
                    WP_ADDR_VALUE: addr_val_q[i]  <= shift_q[31:0];
                    WP_ADDR_MASK:  addr_mask_q[i] <= shift_q[31:0];
                    WP_DATA_VALUE: data_val_q[i]  <= shift_q[31:0];
                    WP_DATA_MASK:  data_mask_q[i] <= shift_q[31:0];
                    WP_CTRL_VALUE: ctrl_val_q[i]  <= shift_q[CTRL_VAL_W-1:0];
                    WP_CTRL_MASK:  ctrl_mask_q[i] <= shift_q[CTRL_MASK_W-1:0];
                    default:       ;
                endcase
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        rd_mux = WORD_RESET;
        if (upd_addr == ADDR_DEBUG_CONTROL)
        begin
            rd_mux[CONTROL_W-1:0] = control_q;
        end
        else if (upd_addr == ADDR_DEBUG_STATUS)
        begin
            rd_mux[STATUS_W-1:0] = status_now;
        end
        else
        begin
            for (int i = 0; i < NUM_WP; i++)
            begin
                if (wp_sel[i])
                begin
                    case (wp_reg)
                        WP_ADDR_VALUE: rd_mux = addr_val_q[i];
                        WP_ADDR_MASK:  rd_mux = addr_mask_q[i];
                        WP_DATA_VALUE: rd_mux = data_val_q[i];
                        WP_DATA_MASK:  rd_mux = data_mask_q[i];
                        WP_CTRL_VALUE: rd_mux[CTRL_VAL_W-1:0] = ctrl_val_q[i];
                        WP_CTRL_MASK:  rd_mux[CTRL_MASK_W-1:0] = ctrl_mask_q[i];
                        default:       rd_mux = WORD_RESET;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rd_hold_q <= WORD_RESET;
        end
        else if (upd_read)
        begin
            rd_hold_q <= rd_mux;
        end
    end

    // Status reflects live core state; a status write is accepted and has no effect.
    assign status_now = {instruction_state_flag, translate_flag, interrupt_enable_status,
                         st_req_s2_q, st_ack_s2_q};

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ext_q <= 2'h0;
        end
        else
        begin
            ext_q <= external_condition;
        end
    end

    // In a 16-bit fetch only the half selected by address bit 1 carries the instruction.
    always_comb
    begin
        half_ignore = WORD_RESET;
        if (instruction_state_flag && !access_kind_bit)
        begin
            half_ignore = core_addr[1] ? LOW_HALF_IGNORE : HIGH_HALF_IGNORE;
        end
    end

    // Comparators; masked bits always match, which also makes ranges aligned powers of two.
    for (genvar i = 0; i < NUM_WP; i++)
    begin : g_cmp
        logic [CTRL_MASK_W-1:0] cbus;
        logic                   chain_in;
        logic                   range_in;

        assign chain_in = (i == 0) ? chain_q : 1'b0;
        // Range coupling is combinational so both watchpoints judge the same bus cycle.
        assign range_in = (i == 0) ? wp_match[1] : 1'b0;
        assign cbus     = {range_in, chain_in, ext_q[i], privilege_bit, access_kind_bit,
                           core_size, core_write};
        assign addr_ok[i] = &(~(core_addr ^ addr_val_q[i]) | addr_mask_q[i]);
        assign data_ok[i] = &(~(core_data ^ data_val_q[i]) | data_mask_q[i]
                              | half_ignore);
        assign ctrl_ok[i] = &(~(cbus ^ ctrl_val_q[i][CTRL_MASK_W-1:0])
                              | ctrl_mask_q[i]);
        assign wp_match[i] = bus_cycle_valid & addr_ok[i] & data_ok[i] & ctrl_ok[i];
        assign wp_fire[i]  = wp_match[i] & ctrl_val_q[i][CV_ENABLE];
    end

    // Sequence-link latch of watchpoint 1.
    always_ff @(posedge mclk)
    begin
        if (srst || ctrl_val_wr[1])
        begin
            chain_q <= 1'b0;
        end
        else if (bus_cycle_valid && addr_ok[1] && ctrl_ok[1])
        begin
            chain_q <= data_ok[1];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            range_q <= 1'b0;
        end
        else
        begin
            range_q <= wp_match[1];
        end
    end

    // Synchronisers: control request bit, and status copies of request and acknowledge.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            req_s1_q    <= 1'b0;
            req_s2_q    <= 1'b0;
            st_req_s1_q <= 1'b0;
            st_req_s2_q <= 1'b0;
            st_ack_s1_q <= 1'b0;
            st_ack_s2_q <= 1'b0;
        end
        else
        begin
            req_s1_q    <= control_q[CTL_FORCE_REQ];
            req_s2_q    <= req_s1_q;
            st_req_s1_q <= dbg_req_q;
            st_req_s2_q <= st_req_s1_q;
            st_ack_s1_q <= dbg_ack_q;
            st_ack_s2_q <= st_ack_s1_q;
        end
    end

    assign eff_ack = core_debug_ack | control_q[CTL_FORCE_ACK];

    // Outputs toward the core and the system.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            break_q   <= 1'b0;
            dbg_req_q <= 1'b0;
            dbg_ack_q <= 1'b0;
            irq_q     <= 1'b0;
            fiq_q     <= 1'b0;
        end
        else
        begin
            break_q   <= debug_unit_enable & (|wp_fire);
            dbg_req_q <= debug_unit_enable & (req_s2_q | ext_debug_request);
            dbg_ack_q <= debug_unit_enable & eff_ack;
            irq_q     <= irq_in & ~(debug_unit_enable
                                    & (eff_ack | control_q[CTL_IRQ_INH]));
            fiq_q     <= fiq_in & ~(debug_unit_enable
                                    & (eff_ack | control_q[CTL_IRQ_INH]));
        end
    end

    assign break_request     = break_q;
    assign debug_request     = dbg_req_q;
    assign debug_ack         = dbg_ack_q;
    assign irq_out           = irq_q;
    assign fiq_out           = fiq_q;
    assign range_out         = range_q;
    assign sequence_link_out = chain_q;
    assign scan_out          = tdo_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_req_forced;
        (control_q[CTL_FORCE_REQ] && debug_unit_enable)[*3];
    endsequence

    sequence s_link_load;
        bus_cycle_valid && addr_ok[1] && ctrl_ok[1] && !ctrl_val_wr[1];
    endsequence

    property p_irq_inhibit;
        debug_unit_enable && (eff_ack || control_q[CTL_IRQ_INH]) |=> !irq_q && !fiq_q;
    endproperty
    a_irq_inhibit: assert property (p_irq_inhibit) else $error("interrupt not inhibited");

    property p_disabled;
        !debug_unit_enable |=> !break_q && !dbg_req_q && !dbg_ack_q && (irq_q == $past(irq_in));
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled unit still active");

    property p_ack_or;
        debug_unit_enable && core_debug_ack |=> dbg_ack_q;
    endproperty
    a_ack_or: assert property (p_ack_or) else $error("ack not passed out");

    property p_req_sync;
        s_req_forced |=> dbg_req_q;
    endproperty
    a_req_sync: assert property (p_req_sync) else $error("forced request lost");

    property p_break_cause;
        break_q |-> $past(debug_unit_enable && (|wp_fire));
    endproperty
    a_break_cause: assert property (p_break_cause) else $error("break without enabled match");

    property p_range_nobreak;
        wp_match[1] && !ctrl_val_q[1][CV_ENABLE] && !wp_fire[0] |=> range_q && !break_q;
    endproperty
    a_range_nobreak: assert property (p_range_nobreak) else $error("range output wrong");

    property p_link_clear;
        ctrl_val_wr[1] |=> !chain_q;
    endproperty
    a_link_clear: assert property (p_link_clear) else $error("link latch not cleared");

    property p_link_load;
        s_link_load |=> chain_q == $past(data_ok[1]);
    endproperty
    a_link_load: assert property (p_link_load) else $error("link latch load wrong");

endmodule : watchpoint_debug_unit

// File: tb/core_model.sv
// Core bus model: presents one watched bus cycle at a time to the comparators.
// Assumes the caller enters cycle() from the bench's main thread on mclk.
`timescale 1ns/1ps
module core_model
(
    input  wire logic        mclk,
    output logic             bus_cycle_valid,
    output logic [31:0]      core_addr,
    output logic [31:0]      core_data,
    output logic             core_write,
    output logic [1:0]       core_size,
    output logic             access_kind_bit,
    output logic             privilege_bit
);
    initial
    begin
        bus_cycle_valid = 1'b0;
        {core_addr, core_data} = {32'hffff_ffff, 32'h0};
        {privilege_bit, access_kind_bit, core_size, core_write} = 5'h1f;
    end

    // Outside a cycle the buses show the inverse of the last value, never a stale copy.
    task automatic cycle(input logic [31:0] a, input logic [31:0] d, input logic [4:0] c);
        @(posedge mclk);
        bus_cycle_valid <= 1'b1;
        {core_addr, core_data} <= {a, d};
        {privilege_bit, access_kind_bit, core_size, core_write} <= c;
        @(posedge mclk);
        bus_cycle_valid <= 1'b0;
        {core_addr, core_data} <= ~{a, d};
        {privilege_bit, access_kind_bit, core_size, core_write} <= ~c;
    endtask : cycle
endmodule : core_model

// File: tb/testbench.sv
// Self-checking bench: programs the unit through its scan chain and drives core cycles.
// Assumes the core_model partner and one-cycle scan strobes on mclk.
`timescale 1ns/1ps
module testbench
    import wdu_pkg::*;
;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        scan_capture = 1'b0, scan_shift = 1'b0, scan_update = 1'b0, scan_in = 1'b0;
    logic        translate_flag = 1'b0, instruction_state_flag = 1'b1;
    logic        interrupt_enable_status = 1'b1, core_debug_ack = 1'b0;
    logic        ext_debug_request = 1'b0, debug_unit_enable = 1'b1;
    logic        irq_in = 1'b1, fiq_in = 1'b1;
    logic [1:0]  external_condition = 2'h0;
    logic        bus_cycle_valid, core_write, access_kind_bit, privilege_bit;
    logic [1:0]  core_size;
    logic [31:0] core_addr, core_data, r;
    logic        scan_out, break_request, debug_request, debug_ack;
    logic        irq_out, fiq_out, range_out, sequence_link_out;
    int          error_cnt = 0;
    int          checks = 0;

    always #2.5 mclk = ~mclk;

    core_model u_core (.mclk(mclk), .bus_cycle_valid(bus_cycle_valid), .core_addr(core_addr),
        .core_data(core_data), .core_write(core_write), .core_size(core_size),
        .access_kind_bit(access_kind_bit), .privilege_bit(privilege_bit));

    watchpoint_debug_unit u_dut (.mclk(mclk), .srst(srst), .scan_capture(scan_capture),
        .scan_shift(scan_shift), .scan_update(scan_update), .scan_in(scan_in),
        .scan_out(scan_out), .bus_cycle_valid(bus_cycle_valid), .core_addr(core_addr),
        .core_data(core_data), .core_write(core_write), .core_size(core_size),
        .access_kind_bit(access_kind_bit), .privilege_bit(privilege_bit),
        .translate_flag(translate_flag), .instruction_state_flag(instruction_state_flag),
        .interrupt_enable_status(interrupt_enable_status), .core_debug_ack(core_debug_ack),
        .ext_debug_request(ext_debug_request), .external_condition(external_condition),
        .debug_unit_enable(debug_unit_enable), .irq_in(irq_in), .fiq_in(fiq_in),
        .break_request(break_request), .debug_request(debug_request), .debug_ack(debug_ack),
        .irq_out(irq_out), .fiq_out(fiq_out), .range_out(range_out),
        .sequence_link_out(sequence_link_out));

    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One full chain pass; the held read word comes out two shifts behind scan_in.
    task automatic scan(input logic [37:0] w, output logic [31:0] q);
        @(posedge mclk);
        scan_capture <= 1'b1;
        for (int i = 0; i < 38; i++)
        begin
            @(posedge mclk);
            if (i >= 2 && i < 34)
                q[i-2] = scan_out;
            {scan_capture, scan_shift, scan_in} <= {2'b01, w[i]};
        end
        @(posedge mclk);
        {scan_shift, scan_update} <= 2'b01;
        @(posedge mclk);
        scan_update <= 1'b0;
    endtask : scan

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        scan({1'b1, a, d}, q);
    endtask : wr

    // A read update loads the hold word; the following capture brings it out.
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        scan({1'b0, a, 32'h0}, q);
        scan({1'b0, a, 32'h0}, q);
    endtask : rd

    task automatic wp(input logic [4:0] b, input logic [31:0] v [6]);
        for (int i = 0; i < 6; i++)
            wr(b + 5'(i), v[i]);
    endtask : wp

    task automatic hit(input logic [31:0] a, d, input logic [4:0] c, input logic [1:0] e);
        u_core.cycle(a, d, c);
        @(negedge mclk);
        chk(32'({range_out, break_request}), 32'(e));
    endtask : hit

    task automatic settle;
        repeat (6) @(negedge mclk);
    endtask : settle

    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop;
    end

    initial
    begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(ADDR_DEBUG_CONTROL, r);
        chk(r, 32'h0);
        wr(ADDR_DEBUG_CONTROL, 32'hffff_fffa);
        rd(ADDR_DEBUG_CONTROL, r);
        chk(r, 32'h2);
        chk(32'(debug_request), 32'h1);
        rd(ADDR_DEBUG_STATUS, r);
        chk(r, 32'h16);
        wr(ADDR_DEBUG_CONTROL, 32'h4);
        settle;
        chk(32'({irq_out, fiq_out, debug_request}), 32'h0);
        wr(ADDR_DEBUG_CONTROL, 32'h0);
        settle;
        chk(32'({irq_out, fiq_out}), 32'h3);
        @(posedge mclk) {core_debug_ack, ext_debug_request} <= 2'b11;
        settle;
        chk(32'({irq_out, fiq_out, debug_request, debug_ack}), 32'h3);
        @(posedge mclk) {core_debug_ack, ext_debug_request, translate_flag} <= 3'b001;
        wr(ADDR_DEBUG_CONTROL, 32'h1);
        rd(ADDR_DEBUG_STATUS, r);
        chk(r, 32'h1d);
        chk(32'({irq_out, fiq_out, debug_ack}), 32'h1);
        @(posedge mclk) {debug_unit_enable, ext_debug_request} <= 2'b01;
        wr(ADDR_DEBUG_CONTROL, 32'h7);
        settle;
        chk(32'({irq_out, fiq_out, debug_request, debug_ack}), 32'hc);
        wp(ADDR_WP0_BASE, '{32'h102, 32'h1, 32'h0, 32'hffff_ffff, 32'h100, 32'hf7});
        hit(32'h102, 32'h0, 5'h00, 2'b00);
        @(posedge mclk) {debug_unit_enable, ext_debug_request} <= 2'b10;
        wr(ADDR_DEBUG_CONTROL, 32'h0);
        hit(32'h102, 32'h0, 5'h00, 2'b01);
        hit(32'h103, 32'h0, 5'h00, 2'b01);
        hit(32'h104, 32'h0, 5'h00, 2'b00);
        hit(32'h102, 32'h0, 5'h08, 2'b00);
        wp(ADDR_WP0_BASE, '{32'h0, 32'hffff_ffff, 32'hdfff_dfff, 32'h0, 32'h100, 32'hf7});
        hit(32'h2, 32'hdfff_1234, 5'h00, 2'b01);
        hit(32'h2, 32'h1234_dfff, 5'h00, 2'b00);
        hit(32'h0, 32'h1234_dfff, 5'h00, 2'b01);
        wp(ADDR_WP0_BASE, '{32'h200, 32'h0, 32'h0, 32'hffff_ffff, 32'h10d, 32'hf0});
        hit(32'h200, 32'h0, 5'h0d, 2'b01);
        hit(32'h200, 32'h0, 5'h0c, 2'b00);
        hit(32'h200, 32'h0, 5'h0b, 2'b00);
        wr(ADDR_WP0_BASE + 5'(WP_CTRL_MASK), 32'hf1);
        hit(32'h200, 32'h0, 5'h0c, 2'b01);
        wp(ADDR_WP1_BASE, '{32'h0, 32'h1f, 32'h0, 32'hffff_ffff, 32'h0, 32'hff});
        wp(ADDR_WP0_BASE, '{32'h0, 32'hff, 32'h0, 32'hffff_ffff, 32'h100, 32'h7f});
        hit(32'h10, 32'h0, 5'h00, 2'b10);
        hit(32'h40, 32'h0, 5'h00, 2'b01);
        hit(32'h100, 32'h0, 5'h00, 2'b00);
        wp(ADDR_WP0_BASE, '{32'h400, 32'h0, 32'h0, 32'hffff_ffff, 32'h140, 32'hbf});
        wp(ADDR_WP1_BASE, '{32'h300, 32'h0, 32'h55, 32'h0, 32'h0, 32'hff});
        hit(32'h400, 32'h0, 5'h00, 2'b00);
        hit(32'h300, 32'h55, 5'h00, 2'b10);
        chk(32'(sequence_link_out), 32'h1);
        hit(32'h400, 32'h0, 5'h00, 2'b01);
        hit(32'h300, 32'h66, 5'h00, 2'b00);
        chk(32'(sequence_link_out), 32'h0);
        hit(32'h300, 32'h55, 5'h00, 2'b10);
        wr(ADDR_WP1_BASE + 5'(WP_CTRL_VALUE), 32'h0);
        settle;
        chk(32'(sequence_link_out), 32'h0);
        wp(ADDR_WP0_BASE, '{32'h500, 32'h0, 32'h0, 32'hffff_ffff, 32'h120, 32'hdf});
        @(posedge mclk) external_condition <= 2'h1;
        hit(32'h500, 32'h0, 5'h00, 2'b01);
        @(posedge mclk) external_condition <= 2'h0;
        hit(32'h500, 32'h0, 5'h00, 2'b00);
        report_and_stop;
    end
endmodule : testbench
